//--- pkg/cbd_defines.svh
// constants for the bus cycle and addressing mode decoder
// assumes inclusion by bare name from rtl files
`ifndef CBD_DEFINES_SVH
`define CBD_DEFINES_SVH
`define CBD_VEC_PAGE 8'hFF
`define CBD_RESET_VEC_LO 8'hFE
`define CBD_SWI_VEC_LO 8'hFC
`define CBD_PREFIX_OP 8'h9E
`define CBD_SP_RESET 16'h00FF
`define CBD_SWI_OP 8'h83
`define CBD_MAX_CYC 4'hF
`endif

//--- pkg/cbd_pkg.sv
// types shared by the decoder and its cycle sequencer
// assumes nothing beyond a SystemVerilog compiler
package cbd_pkg;
  typedef enum logic [3:0] {
    CBD_M_INH, CBD_M_IMM, CBD_M_DIR, CBD_M_EXT, CBD_M_REL, CBD_M_IX,
    CBD_M_IX1, CBD_M_INDEX_OFFSET16, CBD_M_INDEX_POSTINC,
    CBD_M_INDEX_OFFSET8_POSTINC, CBD_M_STACK_OFFSET8, CBD_M_STACK_OFFSET16
  } cbd_mode_t;
  typedef enum logic [2:0] {
    CBD_C_FREE, CBD_C_FETCH, CBD_C_READ, CBD_C_WRITE, CBD_C_PUSH,
    CBD_C_POP, CBD_C_VEC
  } cbd_cyc_t;
endpackage : cbd_pkg

//--- pkg/cbd_seq_if.sv
// carries a decoded instruction from decoder to cycle sequencer
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface cbd_seq_if;
  import cbd_pkg::*;
  logic start;
  logic [3:0] n_cyc;
  logic busy;
  modport dec (output start, n_cyc, input busy);
  modport seq (input start, n_cyc, output busy);
endinterface : cbd_seq_if

//--- rtl/cbd_core.sv
// bus cycle classifier and effective address unit
// Overview of operation
// RULE1 - free cycle: bus unused, one clock, read
// RULE2 - fetch reads next sequential program byte
// RULE3 - vector pair from top page, high first
// RULE4 - push writes one byte to stack
// RULE5 - pop reads one byte from stack
// RULE6 - operand read moves one byte in
// RULE7 - operand write moves one byte out
// RULE8 - postinc mode uses index then increments
// RULE9 - offset8 postinc adds offset then increments
// RULE10 - stack offset8 adds unsigned byte to SP
// RULE11 - stack offset16 adds word to SP
// RULE12 - index offset16 adds word to H:X
// RULE13 - relative adds offset byte to PC
// RULE14 - branch range -128..+127 from next
// RULE15 - decode length, mode, cycles; sequence cycles
// assumes the core feeds opcode, operands, index, SP and PC
`timescale 1ns/1ps
`include "cbd_defines.svh"
module cbd_core
  import cbd_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // instruction from the core
  input wire logic i_op_valid,
  input wire logic i_prefix,
  input wire logic [7:0] i_opcode,
  input wire logic [15:0] i_operand,
  input wire logic i_write_op,
  input wire logic [7:0] i_wdata,
  // core registers
  input wire logic [15:0] i_index,
  input wire logic [15:0] i_sp,
  input wire logic [15:0] i_pc,
  // bus read data
  input wire logic [7:0] i_rdata,
  // decode results
  output logic o_busy,
  output logic [1:0] o_len,
  output cbd_mode_t o_mode,
  output logic [3:0] o_cycles,
  output logic [15:0] o_ea,
  output logic [15:0] o_index_next,
  output logic [15:0] o_branch_pc,
  // system bus
  output cbd_cyc_t o_cyc,
  output logic o_bus_used,
  output logic o_rd,
  output logic [15:0] o_addr,
  output logic [7:0] o_wdata,
  output logic [7:0] o_rbyte
);
  cbd_seq_if sif();
  logic [3:0] left;
  cbd_seq u_seq (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .sif(sif),
    .o_left(left)
  );
  ////////////////////////////////////////////////////////////////////////
  // decode of length, mode and cycle count
  cbd_mode_t mode;
  logic [1:0] len;
  logic [3:0] ncyc;
  logic [3:0] hi;
  logic [3:0] lo;
  always_comb begin
    hi = i_opcode[7:4];
    lo = i_opcode[3:0];
    mode = CBD_M_INH;
    len = 2'd1;
    ncyc = 4'h1;
    if (i_prefix) begin
      unique case (hi)
        4'hD: begin
          mode = CBD_M_STACK_OFFSET16;
          len = 2'd3;
          ncyc = 4'h5;
        end
        default: begin
          mode = CBD_M_STACK_OFFSET8;
          len = 2'd2;
          ncyc = (hi == 4'hE) ? 4'h4 : 4'h6;
        end
      endcase
    end else begin
      unique case (hi)
        4'h2, 4'h9: begin
          mode = (hi == 4'h9 && lo > 4'h3) ? CBD_M_INH : CBD_M_REL;
          len = (mode == CBD_M_REL) ? 2'd2 : 2'd1;
          ncyc = (mode == CBD_M_REL) ? 4'h3 : 4'h1;
        end
        4'h3, 4'hB: begin
          mode = CBD_M_DIR;
          len = 2'd2;
          ncyc = (hi == 4'h3) ? 4'h5 : 4'h3;
        end
        4'h6: begin
          mode = (lo == 4'h1) ? CBD_M_INDEX_OFFSET8_POSTINC : CBD_M_IX1;
          len = (lo == 4'h1) ? 2'd3 : 2'd2;
          ncyc = 4'h5;
        end
        4'h7: begin
          mode = (lo == 4'h1) ? CBD_M_INDEX_POSTINC : CBD_M_IX;
          len = (lo == 4'h1) ? 2'd2 : 2'd1;
          ncyc = (lo == 4'h1) ? 4'h5 : 4'h4;
        end
        4'hA: begin
          mode = CBD_M_IMM;
          len = 2'd2;
          ncyc = 4'h2;
        end
        4'hC: begin
          mode = CBD_M_EXT;
          len = 2'd3;
          ncyc = 4'h4;
        end
        4'hD: begin
          mode = CBD_M_INDEX_OFFSET16;
          len = 2'd3;
          ncyc = 4'h4;
        end
        4'hE: begin
          mode = CBD_M_IX1;
          len = 2'd2;
          ncyc = 4'h3;
        end
        4'hF: begin
          mode = CBD_M_IX;
          len = 2'd1;
          ncyc = 4'h3;
        end
        4'h8: begin
          ncyc = (i_opcode == `CBD_SWI_OP) ? 4'hB : 4'h2;
        end
        default: begin
          mode = CBD_M_INH;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // effective address and branch target
  logic [15:0] ea;
  logic [15:0] rel_ext;
  logic [15:0] next_pc;
  always_comb begin
    next_pc = i_pc + {14'h0000, len};
    // sign extension keeps the target inside -128..+127 of next_pc
    rel_ext = {{8{i_operand[7]}}, i_operand[7:0]}; // RULE14
    ea = i_operand;
    unique case (mode)
      CBD_M_DIR: ea = {8'h00, i_operand[7:0]};
      CBD_M_IX, CBD_M_INDEX_POSTINC: ea = i_index; // RULE8
      CBD_M_IX1: ea = i_index + {8'h00, i_operand[7:0]};
      CBD_M_INDEX_OFFSET8_POSTINC:
        ea = i_index + {8'h00, i_operand[7:0]}; // RULE9
      CBD_M_STACK_OFFSET8: ea = i_sp + {8'h00, i_operand[7:0]}; // RULE10
      CBD_M_STACK_OFFSET16: ea = i_sp + i_operand; // RULE11
      CBD_M_INDEX_OFFSET16: ea = i_index + i_operand; // RULE12
      CBD_M_REL: ea = next_pc + rel_ext; // RULE13
      default: ea = i_operand;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // registered decode outputs and bus cycle
  logic [1:0] len_reg, len_next;
  cbd_mode_t mode_reg, mode_next;
  logic [3:0] cyc_reg, cyc_next;
  logic [15:0] ea_reg, ea_next, ix_reg, ix_next, br_reg, br_next;
  logic [15:0] addr_reg, addr_next, fpc_reg, fpc_next;
  logic [7:0] wd_reg, wd_next, rb_reg, rb_next;
  cbd_cyc_t kind_reg, kind_next;
  logic vec_hi_reg, vec_hi_next;
  logic [2:0] push_reg, push_next;
  logic take;
  always_comb begin
    take = i_op_valid && !sif.busy;
    len_next = len_reg;
    mode_next = mode_reg;
    cyc_next = cyc_reg;
    ea_next = ea_reg;
    ix_next = ix_reg;
    br_next = br_reg;
    wd_next = wd_reg;
    rb_next = rb_reg;
    fpc_next = fpc_reg;
    vec_hi_next = 1'b0;
    push_next = push_reg;
    kind_next = CBD_C_FREE; // RULE1
    addr_next = addr_reg;
    if (take) begin // RULE15
      len_next = len;
      mode_next = mode;
      cyc_next = ncyc;
      ea_next = ea;
      br_next = (mode == CBD_M_REL) ? ea : next_pc;
      ix_next = (mode == CBD_M_INDEX_POSTINC ||
                 mode == CBD_M_INDEX_OFFSET8_POSTINC) ?
                i_index + 16'h0001 : i_index; // RULE8 RULE9
      if (i_opcode == `CBD_SWI_OP && !i_prefix) begin
        // pushed bytes are not seen here, only their stack addresses
        kind_next = CBD_C_PUSH; // RULE4
        addr_next = i_sp;
        push_next = 3'h4;
      end else if (mode == CBD_M_INH || mode == CBD_M_IMM ||
                   mode == CBD_M_REL) begin
        kind_next = CBD_C_FETCH; // RULE2
        fpc_next = fpc_reg + 16'h0001;
        addr_next = fpc_next;
      end else if (i_write_op) begin
        kind_next = CBD_C_WRITE; // RULE7
        wd_next = i_wdata;
        addr_next = ea;
      end else begin
        kind_next = (mode == CBD_M_STACK_OFFSET8 ||
                     mode == CBD_M_STACK_OFFSET16) ?
                    CBD_C_POP : CBD_C_READ; // RULE5 RULE6
        addr_next = ea;
      end
    end else if (push_reg != 3'h0) begin
      // stack grows downward, one byte per push
      kind_next = CBD_C_PUSH; // RULE4
      addr_next = addr_reg - 16'h0001;
      push_next = push_reg - 3'h1;
    end else if (kind_reg == CBD_C_PUSH) begin
      kind_next = CBD_C_VEC; // RULE3
      addr_next = {`CBD_VEC_PAGE, `CBD_SWI_VEC_LO};
      vec_hi_next = 1'b1;
    end else if (vec_hi_reg) begin
      kind_next = CBD_C_VEC; // RULE3
      addr_next = addr_reg + 16'h0001;
    end
    if (kind_reg == CBD_C_READ || kind_reg == CBD_C_POP) begin
      rb_next = i_rdata; // RULE6
    end
  end
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      len_reg <= 2'd0;
      mode_reg <= CBD_M_INH;
      cyc_reg <= 4'h0;
      ea_reg <= 16'h0000;
      ix_reg <= 16'h0000;
      br_reg <= 16'h0000;
      wd_reg <= 8'h00;
      rb_reg <= 8'h00;
      fpc_reg <= 16'h0000;
      addr_reg <= 16'h0000;
      kind_reg <= CBD_C_FREE;
      vec_hi_reg <= 1'b0;
      push_reg <= 3'h0;
    end else begin
      len_reg <= len_next;
      mode_reg <= mode_next;
      cyc_reg <= cyc_next;
      ea_reg <= ea_next;
      ix_reg <= ix_next;
      br_reg <= br_next;
      wd_reg <= wd_next;
      rb_reg <= rb_next;
      fpc_reg <= fpc_next;
      addr_reg <= addr_next;
      kind_reg <= kind_next;
      vec_hi_reg <= vec_hi_next;
      push_reg <= push_next;
    end
  end
  assign sif.start = take;
  assign sif.n_cyc = ncyc;
  assign o_busy = sif.busy || (left > 4'h1);
  assign o_len = len_reg;
  assign o_mode = mode_reg;
  assign o_cycles = cyc_reg;
  assign o_ea = ea_reg;
  assign o_index_next = ix_reg;
  assign o_branch_pc = br_reg;
  assign o_cyc = kind_reg;
  // a free cycle keeps the bus idle but reads as a read cycle
  assign o_bus_used = (kind_reg != CBD_C_FREE); // RULE1
  assign o_rd = (kind_reg != CBD_C_WRITE) &&
                (kind_reg != CBD_C_PUSH); // RULE4 RULE7
  assign o_addr = addr_reg;
  assign o_wdata = wd_reg;
  assign o_rbyte = rb_reg;
endmodule : cbd_core

//--- rtl/cbd_seq.sv
// sequencer: steps through the extra cycles of one instruction
// assumes start is pulsed only while busy is low
`timescale 1ns/1ps
module cbd_seq
  import cbd_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // link to decoder
  cbd_seq_if.seq sif,
  // status
  output logic [3:0] o_left
);
  logic [3:0] cnt_reg, cnt_next;
  always_comb begin
    cnt_next = cnt_reg;
    if (sif.start) begin
      cnt_next = sif.n_cyc;
    end else if (cnt_reg != 4'h0) begin
      cnt_next = cnt_reg - 4'h1;
    end
  end
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign sif.busy = (cnt_reg > 4'h1);
  assign o_left = cnt_reg;
endmodule : cbd_seq

//--- tb/cbd_core_chk.sv
// checker: bus cycle relations at the decoder ports
// assumes it is bound onto cbd_core
`timescale 1ns/1ps
module cbd_core_chk
  import cbd_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // system bus
  input wire cbd_cyc_t o_cyc,
  input wire logic o_bus_used,
  input wire logic o_rd,
  input wire logic [15:0] o_addr
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////
  free_idle_a: assert property (
    o_cyc == CBD_C_FREE |-> o_rd && !o_bus_used)
    else $error("free cycle used the bus");
  fetch_rd_a: assert property (
    o_cyc == CBD_C_FETCH |-> o_rd && o_bus_used)
    else $error("fetch not a read");
  vec_page_a: assert property (
    o_cyc == CBD_C_VEC |-> o_rd && o_addr[15:8] == 8'hFF)
    else $error("vector outside top page");
  vec_pair_a: assert property (
    o_cyc == CBD_C_VEC && $past(o_cyc) != CBD_C_VEC
    |=> o_cyc == CBD_C_VEC && o_addr == $past(o_addr) + 16'h0001)
    else $error("vector pair out of order");
  push_wr_a: assert property (
    o_cyc == CBD_C_PUSH |-> !o_rd && o_bus_used)
    else $error("push not a write");
  push_step_a: assert property (
    o_cyc == CBD_C_PUSH && $past(o_cyc) == CBD_C_PUSH
    |-> o_addr == $past(o_addr) - 16'h0001)
    else $error("push address not one below the last");
  pop_rd_a: assert property (
    o_cyc == CBD_C_POP |-> o_rd && o_bus_used)
    else $error("pop not a read");
  read_one_a: assert property (
    o_cyc == CBD_C_READ |-> o_rd ##1 o_cyc == CBD_C_FREE)
    else $error("operand read not one cycle");
  write_one_a: assert property (
    o_cyc == CBD_C_WRITE |-> !o_rd ##1 o_cyc != CBD_C_WRITE)
    else $error("operand write not one cycle");
endmodule : cbd_core_chk

bind cbd_core cbd_core_chk chk (.i_mclk, .i_arst_n, .o_cyc, .o_bus_used,
  .o_rd, .o_addr);

//--- tb/cbd_core_tb.sv
// bench for the bus cycle and addressing mode decoder
// assumes the memory model answers reads at once
`timescale 1ns/1ps
module cbd_core_tb
  import cbd_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_op_valid = 1'b0;
  logic i_prefix = 1'b0;
  logic i_write_op = 1'b0;
  logic [7:0] i_opcode = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] i_rdata;
  logic [15:0] i_operand = 16'h0000;
  logic [15:0] i_index = 16'h1000;
  logic [15:0] i_sp = 16'h01F0;
  logic [15:0] i_pc = 16'h4000;
  logic o_busy, o_bus_used, o_rd;
  logic [1:0] o_len;
  cbd_mode_t o_mode;
  logic [3:0] o_cycles;
  logic [15:0] o_ea, o_index_next, o_branch_pc, o_addr;
  cbd_cyc_t o_cyc;
  logic [7:0] o_wdata, o_rbyte;
  int n_fail = 0;
  int samples_checked = 0;

  cbd_core uut (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_op_valid(i_op_valid),
    .i_prefix(i_prefix),
    .i_opcode(i_opcode),
    .i_operand(i_operand),
    .i_write_op(i_write_op),
    .i_wdata(i_wdata),
    .i_index(i_index),
    .i_sp(i_sp),
    .i_pc(i_pc),
    .i_rdata(i_rdata),
    .o_busy(o_busy),
    .o_len(o_len),
    .o_mode(o_mode),
    .o_cycles(o_cycles),
    .o_ea(o_ea),
    .o_index_next(o_index_next),
    .o_branch_pc(o_branch_pc),
    .o_cyc(o_cyc),
    .o_bus_used(o_bus_used),
    .o_rd(o_rd),
    .o_addr(o_addr),
    .o_wdata(o_wdata),
    .o_rbyte(o_rbyte)
  );
  cbd_mem mem (.i_mclk, .i_bus_used(o_bus_used), .i_rd(o_rd),
    .i_addr(o_addr), .o_rdata(i_rdata));
  always #5 i_mclk = ~i_mclk;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, ex);
    samples_checked++;
    if (seen !== ex) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // bounded wait for the sequencer to drain before the next take
  task automatic wait_idle();
    int k;
    for (k = 0; k < 40 && o_busy !== 1'b0; k++) begin
      @(posedge i_mclk);
      #1;
    end
    if (o_busy !== 1'b0) begin
      n_fail++;
      print_verdict();
    end
  endtask : wait_idle

  task automatic issue(input logic pre, input logic [7:0] op,
    input logic [15:0] opd, input logic wr);
    wait_idle();
    i_prefix = pre;
    i_opcode = op;
    i_operand = opd;
    i_write_op = wr;
    i_op_valid = 1'b1;
    @(posedge i_mclk);
    #1;
    i_op_valid = 1'b0;
  endtask : issue
  ////////////////////////////////////////
  task automatic t_read();
    issue(1'b0, 8'hC6, 16'h1234, 1'b0);
    chk("cyc", o_cyc, CBD_C_READ);
    chk("addr", o_addr, 16'h1234);
    chk("len", o_len, 2'h3);
    chk("cycles", o_cycles, 4'h4);
    chk("busy", o_busy, 1'b1);
    @(posedge i_mclk);
    #1;
    chk("rbyte", o_rbyte, 8'h26);
    chk("after read", o_cyc, CBD_C_FREE);
    chk("after read bus", o_bus_used, 1'b0);
    $display("test read done");
  endtask : t_read

  task automatic t_write();
    i_wdata = 8'h5A;
    issue(1'b0, 8'hC7, 16'h0080, 1'b1);
    chk("cyc", o_cyc, CBD_C_WRITE);
    chk("rd", o_rd, 1'b0);
    chk("wdata", o_wdata, 8'h5A);
    chk("waddr", o_addr, 16'h0080);
    $display("test write done");
  endtask : t_write

  task automatic t_modes();
    issue(1'b1, 8'hE6, 16'hAAF0, 1'b0);
    chk("stk8 mode", o_mode, CBD_M_STACK_OFFSET8);
    chk("stk8 ea", o_ea, 16'h02E0);
    chk("stk8 cyc", o_cyc, CBD_C_POP);
    issue(1'b1, 8'hD6, 16'h0F00, 1'b0);
    chk("stk16 ea", o_ea, 16'h10F0);
    issue(1'b0, 8'hD6, 16'h8001, 1'b0);
    chk("idx16 ea", o_ea, 16'h9001);
    issue(1'b0, 8'h71, 16'h0000, 1'b0);
    chk("ixp ea", o_ea, 16'h1000);
    chk("ixp idx", o_index_next, 16'h1001);
    issue(1'b0, 8'h61, 16'h2020, 1'b0);
    chk("ix1p ea", o_ea, 16'h1020);
    chk("ix1p idx", o_index_next, 16'h1001);
    $display("test modes done");
  endtask : t_modes

  task automatic t_branch();
    logic [15:0] b;
    issue(1'b0, 8'h20, 16'h0000, 1'b0);
    b = o_branch_pc;
    chk("rel base", b, 16'h4002);
    chk("rel len", o_len, 2'h2);
    chk("fetch", o_cyc, CBD_C_FETCH);
    chk("fetch addr", o_addr, 16'h0001);
    issue(1'b0, 8'h20, 16'h007F, 1'b0);
    chk("fwd", o_branch_pc - b, 16'h007F);
    chk("fetch next", o_addr, 16'h0002);
    issue(1'b0, 8'h20, 16'h0080, 1'b0);
    chk("back", b - o_branch_pc, 16'h0080);
    $display("test branch done");
  endtask : t_branch

  task automatic t_vec();
    int k;
    issue(1'b0, 8'h83, 16'h0000, 1'b0);
    chk("swi cycles", o_cycles, 4'hB);
    chk("push", o_cyc, CBD_C_PUSH);
    chk("push addr", o_addr, 16'h01F0);
    chk("push rd", o_rd, 1'b0);
    @(posedge i_mclk);
    #1;
    chk("push next", o_addr, 16'h01EF);
    for (k = 0; k < 12 && o_cyc !== CBD_C_VEC; k++) begin
      @(posedge i_mclk);
      #1;
    end
    chk("vec hi", o_addr, 16'hFFFC);
    @(posedge i_mclk);
    #1;
    chk("vec lo", o_addr, 16'hFFFD);
    $display("test vector done");
  endtask : t_vec

  task automatic t_idle();
    chk("idle", o_cyc, CBD_C_FREE);
    chk("idle rd", o_rd, 1'b1);
    chk("idle bus", o_bus_used, 1'b0);
    $display("test idle done");
  endtask : t_idle

  initial begin
    repeat (12) @(posedge i_mclk);
    #1;
    i_arst_n = 1'b1;
    t_idle();
    t_read();
    t_write();
    t_modes();
    t_branch();
    t_vec();
    wait_idle();
    print_verdict();
  end
endmodule : cbd_core_tb

//--- tb/cbd_mem.sv
// memory model: answers bus reads with an address-derived byte
// assumes it sees the decoder bus outputs directly
`timescale 1ns/1ps
module cbd_mem (
  // clock
  input wire logic i_mclk,
  // bus from the decoder
  input wire logic i_bus_used,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  output logic [7:0] o_rdata
);
  logic [7:0] last_reg = 8'h00;
  always @(posedge i_mclk) begin
    if (i_bus_used && i_rd) last_reg <= o_rdata;
  end
  // released bus shows the inverse of the last driven byte
  always_comb begin
    if (i_bus_used && i_rd) o_rdata = i_addr[15:8] ^ i_addr[7:0];
    else o_rdata = ~last_reg;
  end
endmodule : cbd_mem
